// >>> logic/rtir_cfg.svh
// Offsets, field masks, reset values and identity defaults of the bank
`ifndef RTIR_CFG_SVH
`define RTIR_CFG_SVH

`define RTIR_LOCAL_HI    8'h40
`define RTIR_LOCAL_LO    8'h41
`define RTIR_REM1_HI     8'h42
`define RTIR_REM1_LO     8'h43
`define RTIR_REM2_HI     8'h44
`define RTIR_REM2_LO     8'h45
`define RTIR_REM3_HI     8'h46
`define RTIR_REM3_LO     8'h47
`define RTIR_REF_FIRST   8'h40
`define RTIR_REF_LAST    8'h47
`define RTIR_MAKER_ADDR  8'h50
`define RTIR_REV_ADDR    8'h51

`define RTIR_FRAC_MASK   8'hF0
`define RTIR_FRAC_ZERO   4'h0
`define RTIR_BYTE_RST    8'h00
`define RTIR_REF_RST     16'h0000
`define RTIR_UNMAPPED    8'h00

`define RTIR_MAKER_DFLT  8'hA5
`define RTIR_REV_DFLT    8'h3C

`endif

// >>> logic/rtir_pkg.sv
// Types shared by the reference temperature register bank
package rtir_pkg;

    typedef logic signed [15:0] rtir_temp_t;

    typedef rtir_temp_t [3:0] rtir_temps_t;

    typedef struct packed
    {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtir_req_t;

endpackage

// >>> logic/rtir_bank.sv
// Reference temperature and identification register bank
`timescale 1ns/100ps
`include "rtir_cfg.svh"

module rtir_bank
#(
    parameter logic [7:0] MAKER_CODE = `RTIR_MAKER_DFLT, // Arbitrary value
    parameter logic [7:0] REV_CODE   = `RTIR_REV_DFLT    // Arbitrary value
)
(
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire rtir_pkg::rtir_req_t   req,
    input  wire logic                  ext_fmt,
    input  wire rtir_pkg::rtir_temps_t meas_temp,
    output logic [7:0]                 rd_data,
    output logic                       rd_valid,
    output rtir_pkg::rtir_temps_t      ref_temp,
    output logic [3:0]                 above_ref
);
    import rtir_pkg::*;

    rtir_temps_t ref_r;
    rtir_temps_t ref_nxt;
    logic [7:0]  maker_r;
    logic [7:0]  maker_nxt;
    logic [7:0]  rev_r;
    logic [7:0]  rev_nxt;
    logic [7:0]  rd_data_r;
    logic [7:0]  rd_data_nxt;
    logic        rd_valid_r;
    logic        rd_valid_nxt;
    logic [3:0]  above_r;
    logic [3:0]  above_nxt;

    function automatic logic is_ref(input logic [7:0] a);
        return (a >= `RTIR_REF_FIRST) && (a <= `RTIR_REF_LAST);
    endfunction

    // Even offset is the upper byte, pairs run from the local channel up
    function automatic logic [1:0] ref_chan(input logic [7:0] a);
        return a[2:1];
    endfunction

    // Storage and write decode
    always_comb
    begin
        ref_nxt   = ref_r;
        maker_nxt = maker_r;
        rev_nxt   = rev_r;
        if (req.wr)
        begin
            if (is_ref(req.addr))
            begin
                if (req.addr[0])
                begin
                    // Low nibble has no storage meaning, forced to zero
                    ref_nxt[ref_chan(req.addr)][7:0] =
                        req.wdata & `RTIR_FRAC_MASK;
                end
                else
                begin
                    // Stored as written; no format translation
                    ref_nxt[ref_chan(req.addr)][15:8] = req.wdata;
                end
            end
            else if (req.addr == `RTIR_MAKER_ADDR)
            begin
                maker_nxt = req.wdata;
            end
            else if (req.addr == `RTIR_REV_ADDR)
            begin
                rev_nxt = req.wdata;
            end
        end
    end

    // Read mux; a read in the cycle of a write returns the old byte
    always_comb
    begin
        rd_valid_nxt = req.rd;
        rd_data_nxt  = rd_data_r;
        if (req.rd)
        begin
            if (is_ref(req.addr))
            begin
                if (req.addr[0])
                begin
                    rd_data_nxt = ref_r[ref_chan(req.addr)][7:0];
                end
                else
                begin
                    rd_data_nxt = ref_r[ref_chan(req.addr)][15:8];
                end
            end
            else if (req.addr == `RTIR_MAKER_ADDR)
            begin
                rd_data_nxt = maker_r;
            end
            else if (req.addr == `RTIR_REV_ADDR)
            begin
                rd_data_nxt = rev_r;
            end
            else
            begin
                rd_data_nxt = `RTIR_UNMAPPED;
            end
        end
    end

    // Signed compare against live measurements; ext_fmt is not consulted
    // because both sides are already in the same encoding
    always_comb
    begin
        above_nxt = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            above_nxt[i] =
                $signed(meas_temp[i]) > $signed(ref_r[i]);
        end
    end

    // Identity bytes are writable, so reset restores them as well
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ref_r   <= {4{`RTIR_REF_RST}};
            maker_r <= MAKER_CODE;
            rev_r   <= REV_CODE;
        end
        else
        begin
            ref_r   <= ref_nxt;
            maker_r <= maker_nxt;
            rev_r   <= rev_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rd_data_r  <= `RTIR_BYTE_RST;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            above_r <= 4'h0;
        end
        else
        begin
            above_r <= above_nxt;
        end
    end

    assign rd_data   = rd_data_r;
    assign rd_valid  = rd_valid_r;
    assign ref_temp  = ref_r;
    assign above_ref = above_r;

    default clocking cb @(posedge clock);
    endclocking

    default disable iff (rst);

    sequence wr_at(logic [7:0] a);
        req.wr && (req.addr == a);
    endsequence

    sequence rd_at(logic [7:0] a);
        req.rd && (req.addr == a);
    endsequence

    local_high_wr_a: assert property (
        wr_at(`RTIR_LOCAL_HI) |=> ref_r[0][15:8] == $past(req.wdata))
        else $error("local upper byte not stored");

    local_low_rd_a: assert property (
        rd_at(`RTIR_LOCAL_LO) |=>
            rd_valid && (rd_data == $past(ref_r[0][7:0])))
        else $error("local lower byte read wrong");

    rem2_high_wr_a: assert property (
        wr_at(`RTIR_REM2_HI) ##1 rd_at(`RTIR_REM2_HI) |=>
            rd_data == $past(req.wdata, 2))
        else $error("remote 2 upper byte read back wrong");

    rem3_low_wr_a: assert property (
        wr_at(`RTIR_REM3_LO) |=>
            ref_r[3][7:4] == $past(req.wdata[7:4]))
        else $error("remote 3 fraction not stored");

    sign_bit_a: assert property (
        wr_at(`RTIR_REM1_HI) |=>
            ref_r[1][15] == $past(req.wdata[7]) &&
            ($signed(ref_r[1]) < 0) == $past(req.wdata[7]))
        else $error("remote 1 sign bit wrong");

    frac_zero_a: assert property (
        ref_r[0][3:0] == `RTIR_FRAC_ZERO &&
        ref_r[1][3:0] == `RTIR_FRAC_ZERO &&
        ref_r[2][3:0] == `RTIR_FRAC_ZERO &&
        ref_r[3][3:0] == `RTIR_FRAC_ZERO)
        else $error("fraction low nibble not zero");

    reset_zero_a: assert property (
        @(posedge clock) disable iff (1'b0)
        $past(rst) |-> ref_r == {4{`RTIR_REF_RST}} && !rd_valid)
        else $error("references not cleared by reset");

    ref_hold_a: assert property (
        !req.wr |=> $stable(ref_r) && ref_temp == ref_r)
        else $error("reference changed without write");

    fmt_keep_a: assert property (
        $changed(ext_fmt) && !req.wr |=> $stable(ref_r))
        else $error("format change altered references");

    maker_rd_a: assert property (
        rd_at(`RTIR_MAKER_ADDR) |=>
            rd_valid && (rd_data == $past(maker_r)))
        else $error("maker code read wrong");

    rev_rd_a: assert property (
        rd_at(`RTIR_REV_ADDR) |=>
            rd_valid && (rd_data == $past(rev_r)))
        else $error("revision code read wrong");

    chan_cmp_a: assert property (
        1'b1 |=> above_ref[2] ==
            ($signed($past(meas_temp[2])) > $signed($past(ref_r[2]))))
        else $error("channel 2 compare wrong");

    unmapped_rd_a: assert property (
        req.rd && !is_ref(req.addr) && req.addr != `RTIR_MAKER_ADDR &&
        req.addr != `RTIR_REV_ADDR |=>
            rd_valid && rd_data == `RTIR_UNMAPPED)
        else $error("unmapped read not zero");

    // Answer stands one cycle; data holds until the next read
    valid_pulse_a: assert property (
        !req.rd |=> !rd_valid)
        else $error("read valid without a read");

    rd_hold_a: assert property (
        !req.rd |=> $stable(rd_data))
        else $error("read data moved without a read");

    local_high_rd_a: assert property (
        rd_at(`RTIR_LOCAL_HI) |=>
            rd_valid && (rd_data == $past(ref_r[0][15:8])))
        else $error("local upper byte read wrong");

    local_low_wr_a: assert property (
        wr_at(`RTIR_LOCAL_LO) |=>
            ref_r[0][7:0] == ($past(req.wdata) & `RTIR_FRAC_MASK))
        else $error("local lower byte not stored");

    rem1_high_rd_a: assert property (
        rd_at(`RTIR_REM1_HI) |=>
            rd_valid && (rd_data == $past(ref_r[1][15:8])))
        else $error("remote 1 upper byte read wrong");

    rem1_low_rd_a: assert property (
        rd_at(`RTIR_REM1_LO) |=>
            rd_valid && (rd_data == $past(ref_r[1][7:0])))
        else $error("remote 1 lower byte read wrong");

    rem2_low_rd_a: assert property (
        rd_at(`RTIR_REM2_LO) |=>
            rd_valid && (rd_data == $past(ref_r[2][7:0])))
        else $error("remote 2 lower byte read wrong");

    rem3_high_rd_a: assert property (
        rd_at(`RTIR_REM3_HI) |=>
            rd_valid && (rd_data == $past(ref_r[3][15:8])))
        else $error("remote 3 upper byte read wrong");

    // Identity bytes take host writes like the references
    maker_wr_a: assert property (
        wr_at(`RTIR_MAKER_ADDR) |=> maker_r == $past(req.wdata))
        else $error("maker code not stored");

    rev_wr_a: assert property (
        wr_at(`RTIR_REV_ADDR) |=> rev_r == $past(req.wdata))
        else $error("revision code not stored");

endmodule

// >>> sim/rtir_host.sv
// Host master model for the bank's parallel register port
`timescale 1ns/100ps
module rtir_host
(
    input  wire logic           clock,
    input  wire logic [7:0]     rd_data,
    input  wire logic           rd_valid,
    output rtir_pkg::rtir_req_t req
);
    import rtir_pkg::*;

    initial req = '0;

    // One-cycle strobes; idle lines show inverted junk, not old values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        req = '{1'b1, 1'b0, a, d};
        @(negedge clock);
        req = '{1'b0, 1'b0, ~a, ~d};
    endtask

    task automatic rd(input  logic [7:0] a,
                      output logic [7:0] d,
                      output logic       v);
        @(negedge clock);
        req = '{1'b0, 1'b1, a, ~a};
        @(negedge clock);
        req = '{1'b0, 1'b0, ~a, a};
        v = rd_valid;
        d = rd_data;
    endtask

    // Write then read the same byte in the very next cycle
    task automatic wr_rd(input  logic [7:0] a,
                         input  logic [7:0] w,
                         output logic [7:0] d,
                         output logic       v);
        @(negedge clock);
        req = '{1'b1, 1'b0, a, w};
        @(negedge clock);
        req = '{1'b0, 1'b1, a, ~w};
        @(negedge clock);
        req = '{1'b0, 1'b0, ~a, w};
        v = rd_valid;
        d = rd_data;
    endtask
endmodule

// >>> sim/test_rtir_bank.sv
// Self-checking bench for the reference temperature register bank
`timescale 1ns/100ps
`include "rtir_cfg.svh"
module test_rtir_bank;
    import rtir_pkg::*;

    logic        clock;
    logic        rst;
    logic        ext_fmt;
    rtir_temps_t meas_temp;
    rtir_req_t   req;
    logic [7:0]  rd_data;
    logic        rd_valid;
    rtir_temps_t ref_temp;
    logic [3:0]  above_ref;
    int          fails;
    int          checks_done;
    logic [7:0]  d;
    logic        v;

    rtir_bank dut_u (.clock(clock), .rst(rst), .req(req),
        .ext_fmt(ext_fmt), .meas_temp(meas_temp), .rd_data(rd_data),
        .rd_valid(rd_valid), .ref_temp(ref_temp), .above_ref(above_ref));

    rtir_host host_u (.clock(clock), .rd_data(rd_data),
        .rd_valid(rd_valid), .req(req));

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    function automatic logic [7:0] pat(input int i);
        return {4'(i + 9), 4'(15 - i)};
    endfunction

    // Odd bytes lose their low nibble in storage
    function automatic logic [7:0] exp_b(input int i);
        return i[0] ? (pat(i) & 8'hF0) : pat(i);
    endfunction

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, d, v);
        chk("rd_valid", 16'h0001, {15'h0000, v});
        chk("rd_data", {8'h00, e}, {8'h00, d});
    endtask

    // Reads all eight reference bytes and the four stored words
    task automatic check_all(input logic z);
        for (int i = 0; i < 8; i++)
            rchk(8'h40 + 8'(i), z ? 8'h00 : exp_b(i));
        for (int c = 0; c < 4; c++)
            chk("ref_temp", z ? 16'h0000 : {exp_b(2 * c),
                exp_b(2 * c + 1)}, ref_temp[c]);
    endtask

    task automatic print_verdict();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        fails++;
        print_verdict();
    end

    initial
    begin
        fails = 0;
        checks_done = 0;
        rst = 1'b1;
        ext_fmt = 1'b0;
        meas_temp = '0;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        check_all(1'b1);
        rchk(8'h50, `RTIR_MAKER_DFLT);
        rchk(8'h51, `RTIR_REV_DFLT);
        $display("test reset values done");
        for (int i = 0; i < 8; i++)
            host_u.wr(8'h40 + 8'(i), pat(i));
        host_u.wr(8'h48, 8'h5A);
        rchk(8'h48, 8'h00);
        host_u.wr(8'h50, 8'h12);
        host_u.wr(8'h51, 8'h34);
        rchk(8'h50, 8'h12);
        rchk(8'h51, 8'h34);
        check_all(1'b0);
        $display("test write readback done");
        // Toggling the format bit must not rewrite anything
        ext_fmt = 1'b1;
        repeat (2) @(negedge clock);
        check_all(1'b0);
        ext_fmt = 1'b0;
        $display("test format toggle done");
        // All refs are negative, so only a signed compare sees all four above
        @(negedge clock);
        chk("above_ref", 16'h000F, {12'h000, above_ref});
        meas_temp[1] = 16'hBDC0;
        @(negedge clock);
        chk("above_ref", 16'h000D, {12'h000, above_ref});
        meas_temp[1] = 16'hBDD0;
        @(negedge clock);
        chk("above_ref", 16'h000F, {12'h000, above_ref});
        $display("test signed compare done");
        // Positive reference on channel 2 drops its above bit
        host_u.wr_rd(8'h44, 8'h66, d, v);
        chk("rd_valid", 16'h0001, {15'h0000, v});
        chk("rd_data", 16'h0066, {8'h00, d});
        chk("above_ref", 16'h000B, {12'h000, above_ref});
        $display("test write then read done");
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        check_all(1'b1);
        rchk(8'h50, `RTIR_MAKER_DFLT);
        rchk(8'h51, `RTIR_REV_DFLT);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
